// ---- verilog/dnio_pkg.sv ----
// package: register map, fields and reset values of the dual nibble io port
`default_nettype none
package dnio_pkg;
  localparam int          DNIO_PORTS      = 2;
  localparam int          DNIO_PORT_W     = 4;
  localparam int          DNIO_LINES      = DNIO_PORTS * DNIO_PORT_W;
  localparam int          DNIO_ADDR_W     = 4;
  localparam int          DNIO_DATA_W     = 8;
  // register offsets
  localparam logic [3:0]  DNIO_OFF_DRIVE  = 4'h0;
  localparam logic [3:0]  DNIO_OFF_SENSE  = 4'h4;
  localparam logic [3:0]  DNIO_OFF_ENABLE = 4'h8;
  // enable register field positions
  localparam int          DNIO_EN_FIRST   = 0;
  localparam int          DNIO_EN_SECOND  = 1;
  // reset values
  localparam logic [7:0]  DNIO_DRIVE_RST  = 8'h00;
  localparam logic [1:0]  DNIO_ENABLE_RST = 2'h0;
  localparam logic [7:0]  DNIO_RDATA_RST  = 8'h00;
endpackage : dnio_pkg
`default_nettype wire

// ---- verilog/dnio_sync_if.sv ----
// interface: raw lines into the synchroniser, clean lines out
`timescale 1ns/1ns
`default_nettype none
interface dnio_sync_if #(parameter int W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport src (output raw, input clean);
  modport snk (input raw, output clean);
endinterface : dnio_sync_if
`default_nettype wire

// ---- verilog/dnio_sync.sv ----
// module: two-flop synchroniser for the external line levels
`timescale 1ns/1ns
`default_nettype none
module dnio_sync #(
  parameter int W = 8
) (
  input  wire logic core_clk,    // system clock
  input  wire logic reset,       // sync reset, active high
  input  wire logic clk_en,      // freeze when low
  dnio_sync_if.snk  sif          // raw in, clean out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] clean_q;
  logic [W-1:0] clean_d;

  // first stage feeds only the second
  always_comb begin
    meta_d  = sif.raw;
    clean_d = meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      meta_q  <= '0;
      clean_q <= '0;
    end else if (clk_en) begin
      meta_q  <= meta_d;
      clean_q <= clean_d;
    end
  end

  assign sif.clean = clean_q;
endmodule : dnio_sync
`default_nettype wire

// ---- verilog/dnio_port.sv ----
// module: dual nibble digital io port with register slave
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module dnio_port
  import dnio_pkg::*;
(
  input  wire logic                   core_clk,             // system clock
  input  wire logic                   reset,                // sync reset, active high
  input  wire logic                   clk_en,               // freezes all state when low
  input  wire logic [DNIO_ADDR_W-1:0] reg_addr,             // register byte address
  input  wire logic [DNIO_DATA_W-1:0] reg_wdata,            // write data
  input  wire logic                   reg_wr,               // write strobe
  input  wire logic                   reg_rd,               // read strobe
  output logic      [DNIO_DATA_W-1:0] reg_rdata,            // read data, cycle after strobe
  input  wire logic [DNIO_PORT_W-1:0] first_port_lines_i,   // first port pin levels
  output logic      [DNIO_PORT_W-1:0] first_port_lines_o,   // first port drive values
  output logic      [DNIO_PORT_W-1:0] first_port_lines_oe_n,  // low while driving
  input  wire logic [DNIO_PORT_W-1:0] second_port_lines_i,  // second port pin levels
  output logic      [DNIO_PORT_W-1:0] second_port_lines_o,  // second port drive values
  output logic      [DNIO_PORT_W-1:0] second_port_lines_oe_n  // low while driving
);
  logic [DNIO_LINES-1:0]  drive_q;
  logic [DNIO_LINES-1:0]  drive_d;
  logic [DNIO_PORTS-1:0]  enable_q;
  logic [DNIO_PORTS-1:0]  enable_d;
  logic [DNIO_DATA_W-1:0] rdata_q;
  logic [DNIO_DATA_W-1:0] rdata_d;
  logic [DNIO_LINES-1:0]  out_q;
  logic [DNIO_LINES-1:0]  out_d;
  logic [DNIO_LINES-1:0]  oe_n_q;
  logic [DNIO_LINES-1:0]  oe_n_d;
  logic [DNIO_LINES-1:0]  sense;
  logic [DNIO_LINES-1:0]  line_en;

  dnio_sync_if #(.W(DNIO_LINES)) sif ();

  // pins come from another domain, so two flops first
  assign sif.raw = {second_port_lines_i, first_port_lines_i};

  dnio_sync #(.W(DNIO_LINES)) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .sif      (sif)
  );

  // per-line selection between read-back and external level
  genvar gi;
  generate
    for (gi = 0; gi < DNIO_LINES; gi++) begin : g_line
      assign line_en[gi] = enable_q[gi / DNIO_PORT_W];
      // enabled port reads the register, not the pin, so no sync lag
      assign sense[gi]   = line_en[gi] ? drive_q[gi] : sif.clean[gi];
    end
  endgenerate

  // register writes, read mux and pin drive next values
  always_comb begin
    drive_d  = drive_q;
    enable_d = enable_q;
    rdata_d  = DNIO_RDATA_RST;
    if (reg_wr) begin
      unique case (reg_addr)
        DNIO_OFF_DRIVE:  drive_d  = reg_wdata;
        DNIO_OFF_ENABLE: enable_d = reg_wdata[DNIO_PORTS-1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        DNIO_OFF_SENSE:  rdata_d = sense;
        DNIO_OFF_ENABLE: rdata_d = {{(DNIO_DATA_W-DNIO_PORTS){1'b0}}, enable_q};
        default:         rdata_d = DNIO_RDATA_RST;  // drive reg is write only
      endcase
    end
    // pins follow the registered state one cycle later
    out_d  = drive_q;
    oe_n_d = ~line_en;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      drive_q  <= DNIO_DRIVE_RST;
      enable_q <= DNIO_ENABLE_RST;
      rdata_q  <= DNIO_RDATA_RST;
      out_q    <= DNIO_DRIVE_RST;
      oe_n_q   <= '1;
    end else if (clk_en) begin
      drive_q  <= drive_d;
      enable_q <= enable_d;
      rdata_q  <= rdata_d;
      out_q    <= out_d;
      oe_n_q   <= oe_n_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign first_port_lines_o     = out_q[DNIO_PORT_W-1:0];
  assign second_port_lines_o    = out_q[DNIO_LINES-1:DNIO_PORT_W];
  assign first_port_lines_oe_n  = oe_n_q[DNIO_PORT_W-1:0];
  assign second_port_lines_oe_n = oe_n_q[DNIO_LINES-1:DNIO_PORT_W];

  // checks: pin drive follows the drive register one edge late
  chk_first_drive: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && !first_port_lines_oe_n[0]) |-> first_port_lines_o == $past(drive_q[3:0]))
    else $error("first port drive mismatch");
  chk_second_drive: assert property (
    @(posedge core_clk) disable iff (reset)
    $past(clk_en) && $past(enable_q[DNIO_EN_SECOND]) |-> second_port_lines_o == $past(drive_q[7:4]))
    else $error("second port drive mismatch");

  // checks: read-back of enabled ports, whole and per nibble
  chk_readback_val: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_rd && reg_addr == DNIO_OFF_SENSE && enable_q == 2'h3) |=> reg_rdata == $past(drive_q))
    else $error("read-back differs from drive");
  chk_first_readback: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_rd && reg_addr == DNIO_OFF_SENSE && enable_q == 2'h1)
      |=> reg_rdata[3:0] == $past(drive_q[3:0]))
    else $error("first port read-back wrong");
  chk_second_readback: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_rd && reg_addr == DNIO_OFF_SENSE && enable_q == 2'h2)
      |=> reg_rdata[7:4] == $past(drive_q[7:4]))
    else $error("second port read-back wrong");

  // checks: a disabled port lets go of all four lines, an enabled first port drives all four
  chk_disabled_undriven: assert property (
    @(posedge core_clk) disable iff (reset)
    $past(clk_en) && !$past(enable_q[DNIO_EN_FIRST]) |-> first_port_lines_oe_n == 4'hf)
    else $error("disabled port is driven");
  chk_second_undriven: assert property (
    @(posedge core_clk) disable iff (reset)
    $past(clk_en) && !$past(enable_q[DNIO_EN_SECOND]) |-> second_port_lines_oe_n == 4'hf)
    else $error("disabled second port is driven");
  chk_first_oe_follow: assert property (
    @(posedge core_clk) disable iff (reset)
    $past(clk_en) && $past(enable_q[DNIO_EN_FIRST]) |-> first_port_lines_oe_n == 4'h0)
    else $error("enabled first port not driven");

  // checks: the four lines of a port always turn together
  chk_first_group: assert property (
    @(posedge core_clk) disable iff (reset)
    first_port_lines_oe_n == 4'h0 || first_port_lines_oe_n == 4'hf)
    else $error("first port lines split");
  chk_second_group: assert property (
    @(posedge core_clk) disable iff (reset)
    second_port_lines_oe_n == 4'h0 || second_port_lines_oe_n == 4'hf)
    else $error("second port lines split");

  // checks: sense of external levels through the synchroniser, writes to sense change no state
  chk_sense_ext: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_rd && reg_addr == DNIO_OFF_SENSE && enable_q == 2'h0) |=> reg_rdata == $past(sif.clean))
    else $error("sense value not external level");
  chk_sense_wr_ignored: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_wr && reg_addr == DNIO_OFF_SENSE) |=> $stable(drive_q) && $stable(enable_q))
    else $error("write to sense changed state");

  // checks: register writes land, write-only drive reads as zero
  chk_enable_write: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_wr && reg_addr == DNIO_OFF_ENABLE) |=> enable_q == $past(reg_wdata[1:0]))
    else $error("enable write lost");
  chk_drive_write: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_wr && reg_addr == DNIO_OFF_DRIVE) |=> drive_q == $past(reg_wdata))
    else $error("drive write lost");
  chk_drive_read_zero: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && reg_rd && reg_addr == DNIO_OFF_DRIVE) |=> reg_rdata == 8'h00)
    else $error("drive register readable");

  // checks: read data stand one cycle only, frozen state holds
  chk_rdata_idle: assert property (
    @(posedge core_clk) disable iff (reset)
    (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
    else $error("read data outlived its cycle");
  chk_freeze_state: assert property (
    @(posedge core_clk) disable iff (reset)
    !clk_en |=> $stable(drive_q) && $stable(enable_q) && $stable(reg_rdata))
    else $error("state moved while frozen");

  // checks: reset leaves every line released and drive cleared
  chk_reset_clear: assert property (
    @(posedge core_clk)
    reset |=> (drive_q == 8'h00 && enable_q == 2'h0 && oe_n_q == 8'hff))
    else $error("reset state wrong");
endmodule : dnio_port
`default_nettype wire

// ---- sim/dnio_ext_model.sv ----
// model: outside equipment resolving each connector line
`timescale 1ns/1ns
`default_nettype none
module dnio_ext_model (
  input  wire logic [7:0] oe_n,   // low while the port drives
  input  wire logic [7:0] o,      // port drive values
  input  wire logic [7:0] ext,    // levels applied from outside
  output logic      [7:0] level   // resolved line levels
);
  // an undriven line shows whatever the equipment applies
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      level[i] = oe_n[i] ? ext[i] : o[i];
    end
  end
endmodule : dnio_ext_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// testbench: register access and line behaviour of the io port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dnio_pkg::*;
  logic       core_clk  = 1'b0;
  logic       reset     = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       clk_en    = 1'b1;
  logic [7:0] ext       = 8'ha5;
  wire logic [7:0] reg_rdata, lvl, o, oe_n;
  int         errors = 0;
  int         comparisons = 0;
  // 50 MHz clock
  always #10 core_clk = ~core_clk;
  dnio_port dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .first_port_lines_i(lvl[3:0]), .first_port_lines_o(o[3:0]), .first_port_lines_oe_n(oe_n[3:0]),
    .second_port_lines_i(lvl[7:4]), .second_port_lines_o(o[7:4]), .second_port_lines_oe_n(oe_n[7:4]));
  dnio_ext_model ext_eq (.oe_n(oe_n), .o(o), .ext(ext), .level(lvl));
  task automatic end_sim;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // waits out pin lag and the input synchroniser, then reads sense
  task automatic sense(input logic [7:0] exp);
    repeat (4) @(posedge core_clk);
    reg_addr <= DNIO_OFF_SENSE;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check("sense", reg_rdata, exp);
    @(posedge core_clk);
    #1;
    check("rdata_idle", reg_rdata, 8'h00);
  endtask : sense
  task automatic t_reset;
    check("oe_n", oe_n, 8'hff);
    check("drive", o, 8'h00);
    sense(8'ha5);
  endtask : t_reset
  // a write taken while clk_en is low must not land
  task automatic t_freeze;
    wr(DNIO_OFF_ENABLE, 8'h03);
    clk_en <= 1'b0;
    wr(DNIO_OFF_DRIVE, 8'hff);
    clk_en <= 1'b1;
    sense(8'h00);
    check("frozen", o, 8'h00);
    wr(DNIO_OFF_ENABLE, 8'h00);
  endtask : t_freeze
  task automatic t_first;
    wr(DNIO_OFF_DRIVE, 8'h3c);
    wr(DNIO_OFF_ENABLE, 8'h01);
    ext <= 8'h5a;
    sense(8'h5c);
    check("oe_n", oe_n, 8'hf0);
    check("first", {4'h0, o[3:0]}, 8'h0c);
  endtask : t_first
  task automatic t_second;
    wr(DNIO_OFF_ENABLE, 8'h02);
    wr(DNIO_OFF_SENSE, 8'hff);
    sense(8'h3a);
    check("oe_n", oe_n, 8'h0f);
    check("second", {4'h0, o[7:4]}, 8'h03);
  endtask : t_second
  task automatic t_both;
    wr(DNIO_OFF_DRIVE, 8'h96);
    wr(DNIO_OFF_ENABLE, 8'h03);
    sense(8'h96);
    check("oe_n", oe_n, 8'h00);
    wr(DNIO_OFF_ENABLE, 8'h00);
    ext <= 8'hc3;
    sense(8'hc3);
    check("oe_n", oe_n, 8'hff);
    wr(DNIO_OFF_ENABLE, 8'h03);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    sense(8'hc3);
    check("drive", o, 8'h00);
    check("oe_n", oe_n, 8'hff);
  endtask : t_both
  // hang guard
  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    t_reset();
    t_freeze();
    t_first();
    t_second();
    t_both();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
